// file: include/urx_pkg.sv
// Purpose: constants for the receive, error, interrupt and wake block
// Assumes: apb slave, 32-bit data, one clock of 100 MHz
// Notes:   bit layouts of all registers live here
// Behaviour
// RULE_01 - two buffered words, third completing flags overrun
// RULE_02 - overrun keeps buffer, drops word, may interrupt
// RULE_03 - overrun clears on status then data read
// RULE_04 - noise flag set with receive-available, word kept
// RULE_05 - noise flag never interrupts on its own
// RULE_06 - noise clears on status then data read
// RULE_07 - low first stop bit sets framing error
// RULE_08 - framing error buffered with word, reset clears
// RULE_09 - parity error only with parity enabled
// RULE_10 - error flags travel with word; read first
// RULE_11 - single active-low pulse from six sources
// RULE_12 - own tx enables, shared receive enable
// RULE_13 - address detect interrupts without any flag
// RULE_14 - address mode: interrupt only if top bit high
// RULE_15 - no address mode: interrupt on every word
// RULE_16 - software clears parity when address mode on
// RULE_17 - status flags read-only, changed by uart only
// RULE_18 - halted clock freezes reception, then resumes
// RULE_19 - low-power modes keep all registers unchanged
// RULE_20 - rx falling edge wakes when all enables set
// RULE_21 - wake interrupt needs global and serial enables
// RULE_22 - rx ignored and wake irq held during startup
// RULE_23 - word moved to buffer requests receive interrupt
package urx_pkg;
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
  localparam logic [7:0] ADDR_BAUD     = 8'h0C;
  localparam logic [7:0] ADDR_RX_DATA  = 8'h10;
  // uart_control_one fields
  localparam int C1_UNIT_EN = 0;
  localparam int C1_NINE    = 1;
  localparam int C1_PAR_EN  = 2;
  localparam int C1_PAR_ODD = 3;
  localparam int C1_TWO_STOP = 4;
  // uart_control_two fields
  localparam int C2_RX_EN    = 0;
  localparam int C2_ADDR     = 1;
  localparam int C2_WAKE     = 2;
  localparam int C2_RX_IRQ   = 3;
  localparam int C2_TXE_IRQ  = 4;
  localparam int C2_TXI_IRQ  = 5;
  // uart_status_reg fields
  localparam int ST_AVAIL = 0;
  localparam int ST_OVR   = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAME = 3;
  localparam int ST_PAR   = 4;
  localparam int ST_IDLE  = 5;
  localparam int ST_TXE   = 6;
  localparam int ST_TXI   = 7;
  localparam logic [5:0]  CTRL_ONE_RST = 6'h00;
  localparam logic [5:0]  CTRL_TWO_RST = 6'h00;
  localparam logic [15:0] BAUD_RST     = 16'h0000;
  // oversampling: 16 ticks a bit, three samples around the middle
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_B = 4'h8;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_NS    = 20000;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP   = 3'b110
  } urx_state_e;
endpackage : urx_pkg

// file: verilog/urx_core.sv
// Purpose: uart receive path with error flags, interrupt pulse and rx wake-up
// Assumes: all inputs synchronous to pclk; transmitter lives elsewhere
// Notes:   registers reached over apb, one wait state on every access
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module urx_core
  import urx_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  input  wire logic        tx_empty,
  input  wire logic        tx_idle,
  input  wire logic        clock_halted,
  input  wire logic        deep_idle_state,
  input  wire logic        global_irq_enable,
  input  wire logic        serial_irq_enable,
  output logic             uart_irq_n,
  output logic             wake_event
);
  // a zero count would wrap the 32-bit counter and hold the startup window for about 2^32 cycles
  if (STARTUP_COUNT < 1) begin : g_bad_startup
    $error("startup count must be at least one");
  end

  // registers
  logic [5:0]  uart_control_one;
  logic [5:0]  uart_control_two;
  logic [15:0] baud_divisor_reg;
  logic        overrun_flag;
  logic        status_armed;

  wire serial_unit_enable = uart_control_one[C1_UNIT_EN];
  wire nine_bit_select    = uart_control_one[C1_NINE];
  wire parity_enable      = uart_control_one[C1_PAR_EN];
  wire parity_odd         = uart_control_one[C1_PAR_ODD];
  wire receiver_enable    = uart_control_two[C2_RX_EN];
  wire address_match_mode = uart_control_two[C2_ADDR];
  wire wake_enable        = uart_control_two[C2_WAKE];
  wire rx_irq_enable      = uart_control_two[C2_RX_IRQ];

  // full compare: aliases of a register would disturb the clear sequence
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  // apb decode
  wire acc_done   = psel & penable & pready;
  wire wr_done    = acc_done & pwrite;
  wire rd_done    = acc_done & ~pwrite;
  wire sel_status = is_reg(paddr, ADDR_STATUS);
  wire sel_c1     = is_reg(paddr, ADDR_CTRL_ONE);
  wire sel_c2     = is_reg(paddr, ADDR_CTRL_TWO);
  wire sel_baud   = is_reg(paddr, ADDR_BAUD);
  wire sel_data   = is_reg(paddr, ADDR_RX_DATA);
  wire mapped     = sel_status | sel_c1 | sel_c2 | sel_baud | sel_data;
  wire next_pready = psel & penable & ~pready;

  // two-entry receive buffer: 9 data bits, noise, frame, parity
  logic [11:0] rx_data_buffer [2];
  logic        wr_idx;
  logic        rd_idx;
  logic [1:0]  fill;
  wire [11:0]  head       = rx_data_buffer[rd_idx];
  wire         rx_available_flag = (fill != 2'b00);
  wire         buf_full   = (fill == 2'b10);
  // the clear sequence: a status read, then a data read
  wire         pop        = rd_done & sel_data & status_armed & rx_available_flag; // RULE_03

  // status word; flags are only read, never written by software
  wire [7:0] uart_status_reg; // RULE_17
  logic      rx_idle;
  assign uart_status_reg[ST_AVAIL] = rx_available_flag;
  assign uart_status_reg[ST_OVR]   = overrun_flag;
  assign uart_status_reg[ST_NOISE] = rx_available_flag & head[9];  // RULE_06
  assign uart_status_reg[ST_FRAME] = rx_available_flag & head[10]; // RULE_10
  assign uart_status_reg[ST_PAR]   = rx_available_flag & head[11]; // RULE_10
  assign uart_status_reg[ST_IDLE]  = rx_idle;
  assign uart_status_reg[ST_TXE]   = tx_empty;
  assign uart_status_reg[ST_TXI]   = tx_idle;

  wire [31:0] rd_mux = sel_status ? {24'h000000, uart_status_reg} :
                       sel_c1     ? {26'h0000000, uart_control_one} :
                       sel_c2     ? {26'h0000000, uart_control_two} :
                       sel_baud   ? {16'h0000, baud_divisor_reg} :
                       sel_data   ? {23'h000000, head[8:0]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pready & ~mapped;
      if (next_pready) begin
        prdata <= rd_mux;
      end
    end
  end

  // control registers hold through idle and sleep: nothing here sees the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_control_one <= CTRL_ONE_RST;
      uart_control_two <= CTRL_TWO_RST;
      baud_divisor_reg <= BAUD_RST;
    end else if (wr_done) begin // RULE_19
      if (sel_c1) uart_control_one <= pwdata[5:0];
      if (sel_c2) uart_control_two <= pwdata[5:0];
      if (sel_baud) baud_divisor_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_armed <= 1'b0;
    end else if (acc_done) begin
      status_armed <= ~pwrite & sel_status;
    end
  end

  // wake-up and startup delay
  logic [31:0] startup_cnt;
  logic        starting;
  logic        rx_prev;
  logic        wake_irq;
  wire rx_fall   = rx_prev & ~rx_line;
  wire wake_armed = wake_enable & serial_unit_enable & receiver_enable & rx_irq_enable;
  wire wake_hit  = deep_idle_state & wake_armed & rx_fall & ~starting; // RULE_20
  wire start_end = starting & (startup_cnt == 32'd1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_prev    <= 1'b1;
      wake_event <= 1'b0;
      wake_irq   <= 1'b0;
    end else begin
      rx_prev    <= rx_line;
      wake_event <= wake_hit;
      wake_irq   <= start_end & global_irq_enable & serial_irq_enable; // RULE_21
    end
  end

  // the count runs from the wake edge; reception stays blocked meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      starting    <= 1'b0;
      startup_cnt <= 32'd0;
    end else if (wake_hit) begin
      starting    <= 1'b1;
      startup_cnt <= 32'(STARTUP_COUNT);
    end else if (starting) begin
      startup_cnt <= startup_cnt - 32'd1;
      if (start_end) starting <= 1'b0; // RULE_22
    end
  end

  // receiver runs only with a live clock, enabled, and not during startup
  wire rx_run = serial_unit_enable & receiver_enable & ~clock_halted & ~starting
                & ~deep_idle_state; // RULE_18 RULE_22

  // oversampling divider: one tick per baud_divisor+1 clocks
  logic [15:0] div_cnt;
  wire         tick = rx_run & (div_cnt == baud_divisor_reg);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 16'h0000;
    end else if (rx_run) begin // RULE_18
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
    end
  end

  // receive state machine
  urx_state_e  state;
  urx_state_e  next_state;
  logic [3:0]  sub;
  logic [3:0]  bit_cnt;
  logic [8:0]  shreg;
  logic [2:0]  samp;
  logic        noisy;
  logic        pbit;

  // majority of the three middle samples; any disagreement counts as noise
  function automatic logic vote(input logic [2:0] s);
    vote = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction : vote

  function automatic logic disagree(input logic [2:0] s);
    disagree = ~(&s) & (|s);
  endfunction : disagree

  wire [2:0] samp_now = {samp[1:0], rx_line};
  wire       bit_val  = vote(samp_now);
  wire       bit_noisy = disagree(samp_now);
  wire       decide   = tick & (sub == SAMP_C);
  wire [3:0] data_bits = nine_bit_select ? 4'h9 : 4'h8;
  wire       last_data = (bit_cnt == data_bits - 4'h1);
  wire       frame_err = ~bit_val; // RULE_07
  wire [8:0] word      = nine_bit_select ? shreg : {1'b0, shreg[8:1]};
  wire       par_err   = parity_enable & ((^word ^ pbit) != parity_odd); // RULE_09
  wire       top_bit   = shreg[8]; // RULE_14
  wire       done      = (state == RX_STOP) & decide;
  wire       push      = done & ~buf_full; // RULE_01
  wire       ovr_event = done & buf_full; // RULE_02

  always_comb begin
    next_state = state;
    unique case (state)
      RX_IDLE:   if (rx_run & rx_fall) next_state = RX_START;
      RX_START:  if (decide) next_state = bit_val ? RX_IDLE : RX_DATA;
      RX_DATA:   if (decide & last_data) next_state = parity_enable ? RX_PARITY : RX_STOP;
      RX_PARITY: if (decide) next_state = RX_STOP;
      RX_STOP:   if (decide) next_state = RX_IDLE;
    endcase
    if (!(serial_unit_enable & receiver_enable)) next_state = RX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RX_IDLE;
    end else if (rx_run | ~(serial_unit_enable & receiver_enable)) begin // RULE_18
      state <= next_state;
    end
  end

  // the sample window counter restarts at each start edge
  wire in_idle    = (state == RX_IDLE);
  wire start_seen = rx_run & rx_fall;
  wire samp_slot  = (sub == SAMP_A) | (sub == SAMP_B) | (sub == SAMP_C);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub <= 4'h0;
    end else if (in_idle) begin
      sub <= 4'h0;
    end else if (tick) begin
      sub <= sub + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp <= 3'b111;
    end else if (tick & ~in_idle & samp_slot) begin
      samp <= samp_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 4'h0;
      shreg   <= 9'h000;
    end else if (in_idle) begin
      bit_cnt <= 4'h0;
    end else if (decide && state == RX_DATA) begin
      shreg   <= {bit_val, shreg[8:1]};
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      noisy <= 1'b0;
      pbit  <= 1'b0;
    end else if (in_idle) begin
      noisy <= 1'b0;
    end else if (decide) begin
      noisy <= noisy | bit_noisy; // RULE_04
      if (state == RX_PARITY) pbit <= bit_val;
    end
  end

  // idle drops on the start edge itself, so software sees a frame begin at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_idle <= 1'b1;
    end else begin
      rx_idle <= in_idle & ~start_seen;
    end
  end

  // buffer writes carry the error flags beside the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_buffer[0] <= 12'h000;
      rx_data_buffer[1] <= 12'h000;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      fill   <= 2'b00;
    end else begin
      if (push) begin
        rx_data_buffer[wr_idx] <= {par_err, frame_err, noisy | bit_noisy, word}; // RULE_08 RULE_10
        wr_idx <= ~wr_idx;
      end
      if (pop) rd_idx <= ~rd_idx;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // overrun stays until the clear sequence; a new overrun wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_flag <= 1'b0;
    end else if (ovr_event) begin
      overrun_flag <= 1'b1; // RULE_02
    end else if (pop) begin
      overrun_flag <= 1'b0; // RULE_03
    end
  end

  // interrupt sources; noise adds no source of its own
  logic tx_empty_d;
  logic tx_idle_d;
  wire  addr_ok   = ~address_match_mode | top_bit; // RULE_14 RULE_15
  wire  rx_irq    = rx_irq_enable & push & addr_ok; // RULE_23 RULE_05
  wire  addr_irq  = address_match_mode & push & top_bit; // RULE_13
  wire  ovr_irq   = rx_irq_enable & ovr_event; // RULE_02 RULE_12
  wire  txe_irq   = uart_control_two[C2_TXE_IRQ] & tx_empty & ~tx_empty_d; // RULE_12
  wire  txi_irq   = uart_control_two[C2_TXI_IRQ] & tx_idle & ~tx_idle_d; // RULE_12
  wire  any_irq   = rx_irq | addr_irq | ovr_irq | txe_irq | txi_irq | wake_irq;

  // transmitter levels interrupt only on their rising edge, not while they stay high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_empty_d <= 1'b0;
      tx_idle_d  <= 1'b0;
    end else begin
      tx_empty_d <= tx_empty;
      tx_idle_d  <= tx_idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_irq_n <= 1'b1;
    end else begin
      uart_irq_n <= ~any_irq; // RULE_11
    end
  end
endmodule : urx_core
`default_nettype wire

// file: verif/urx_tx_model.sv
// Purpose: remote serial transmitter that drives the receive line
// Assumes: divisor 0, so sixteen pclk cycles a bit; idle line high
// Notes:   glitch flips one cycle of data bit 0 near the middle samples
`timescale 1ns/10ps
`default_nettype none
module urx_tx_model (
  input  wire logic pclk,
  input  wire logic hold,
  output logic      rx_line
);
  initial rx_line = 1'b1;
  // pm: 0 no parity, 1 even, 2 odd; bad inverts the parity bit
  task automatic send(input logic [8:0] d, input int nb, input int pm, input logic bad,
                      input logic stop, input logic glitch);
    logic [11:0] f;
    int          n;
    f = '0;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    n = nb + 1;
    if (pm != 0) begin
      f[n] = ^(d & ((9'h001 << nb) - 9'h001)) ^ (pm == 2) ^ bad;
      n++;
    end
    f[n] = stop;
    for (int i = 0; i <= n; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge pclk);
        while (hold) @(posedge pclk);
        rx_line <= (glitch && i == 1 && t == 8) ? ~f[i] : f[i];
      end
    end
    @(posedge pclk);
    rx_line <= 1'b1;
  endtask : send
  task automatic low(input int n);
    @(posedge pclk);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
  endtask : low
endmodule : urx_tx_model
`default_nettype wire

// file: verif/urx_core_props.sv
// Purpose: port-level assertions for the receive, interrupt and wake block
// Assumes: tx inputs steady while waking or halted
// Notes:   the startup window is counted in helper logic
`timescale 1ns/10ps
`default_nettype none
module urx_core_props
  import urx_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_line,
  input wire logic        tx_empty,
  input wire logic        tx_idle,
  input wire logic        clock_halted,
  input wire logic        deep_idle_state,
  input wire logic        global_irq_enable,
  input wire logic        serial_irq_enable,
  input wire logic        uart_irq_n,
  input wire logic        wake_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] since_wake;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_wake <= 16'h0000;
    else if (wake_event) since_wake <= 16'h0001;
    else if (since_wake != 16'h0000 && since_wake < 16'hFFFF) since_wake <= since_wake + 16'h0001;
  end
  chk_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  chk_irq_single_pulse: assert property (!uart_irq_n |=> uart_irq_n)
    else $error("irq pulse too long");
  chk_wake_single_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake pulse too long");
  chk_wake_cause: assert property (wake_event |-> $past(deep_idle_state) && !$past(rx_line))
    else $error("wake without rx fall in deep idle");
  chk_wake_startup_quiet: assert property (since_wake != 0 && since_wake < STARTUP_COUNT |-> uart_irq_n)
    else $error("irq during startup delay");
  chk_halt_no_irq: assert property (clock_halted && $past(clock_halted) |-> uart_irq_n)
    else $error("irq while halted");
endmodule : urx_core_props
bind urx_core urx_core_props #(.STARTUP_COUNT(STARTUP_COUNT)) i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rx_line, .tx_empty, .tx_idle, .clock_halted, .deep_idle_state, .global_irq_enable,
  .serial_irq_enable, .uart_irq_n, .wake_event
);
`default_nettype wire

// file: verif/urx_core_test.sv
// Purpose: self-checking bench for the receive, error, interrupt and wake block
// Assumes: divisor 0, sixteen clocks a bit; startup shortened to 5 cycles
// Notes:   tx inputs held steady around frames so irq counts stay exact
`timescale 1ns/10ps
`default_nettype none
module urx_core_test
  import urx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, err;
  logic        tx_empty, tx_idle, clock_halted, deep_idle_state, uart_irq_n, wake_event;
  logic        global_irq_enable, serial_irq_enable;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          mismatches = 0, samples_checked = 0, irqs = 0, wakes = 0, c, w;
  logic [8:0]  ad [4] = '{9'h012, 9'h092, 9'h080, 9'h100};
  urx_core #(.STARTUP_COUNT(5)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_line, .tx_empty, .tx_idle, .clock_halted,
    .deep_idle_state, .global_irq_enable, .serial_irq_enable, .uart_irq_n, .wake_event);
  urx_tx_model i_tx (.pclk, .hold(clock_halted), .rx_line);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (uart_irq_n === 1'b0) irqs++;
    if (wake_event === 1'b1) wakes++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), r & m, e);
  endtask : rd
  task automatic wake(input logic [31:0] c2, input logic g, input int ew, ei);
    apb(1'b1, ADDR_CTRL_TWO, c2);
    global_irq_enable <= g;
    serial_irq_enable <= g;
    deep_idle_state   <= 1'b1;
    c = irqs;
    w = wakes;
    i_tx.low(40);
    repeat (30) @(posedge pclk);
    chk("wake", wakes - w, ew);
    chk("wake irq", irqs - c, ei);
    deep_idle_state <= 1'b0;
    rd(ADDR_STATUS, 32'h1, 32'h0);
  endtask : wake
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  initial begin
    {psel, penable, pwrite, tx_empty, tx_idle, clock_halted, deep_idle_state} = '0;
    {global_irq_enable, serial_irq_enable, paddr, pwdata, presetn} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_BAUD, 32'hFFFF, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hFF);
    rd(ADDR_STATUS, 32'h3F, 32'h20);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, ADDR_CTRL_ONE, 32'h3F);
    rd(ADDR_CTRL_ONE, 32'hFFFFFFFF, 32'h3F);
    apb(1'b1, ADDR_CTRL_ONE, 32'h1);
    apb(1'b1, ADDR_CTRL_TWO, 32'h9);
    c = irqs;
    i_tx.send(9'h055, 8, 0, 0, 1, 0);
    chk("rx irq", irqs - c, 1);
    rd(ADDR_STATUS, 32'h1F, 32'h1);
    rd(ADDR_RX_DATA, 32'h1FF, 32'h55);
    c = irqs;
    for (int i = 1; i < 4; i++) i_tx.send(9'(i), 8, 0, 0, 1, 0);
    chk("overrun irq", irqs - c, 3);
    rd(ADDR_STATUS, 32'h3, 32'h3);
    apb(1'b0, ADDR_CTRL_ONE, 32'h0);
    apb(1'b0, ADDR_RX_DATA, 32'h0);
    rd(ADDR_STATUS, 32'h3, 32'h3);
    rd(ADDR_RX_DATA, 32'h1FF, 32'h1);
    rd(ADDR_STATUS, 32'h3, 32'h1);
    rd(ADDR_RX_DATA, 32'h1FF, 32'h2);
    c = irqs;
    i_tx.send(9'h0A5, 8, 0, 0, 1, 1);
    chk("noise irq", irqs - c, 1);
    rd(ADDR_STATUS, 32'h5, 32'h5);
    rd(ADDR_RX_DATA, 32'h1FF, 32'hA5);
    rd(ADDR_STATUS, 32'h4, 32'h0);
    i_tx.send(9'h03C, 8, 0, 0, 0, 0);
    rd(ADDR_STATUS, 32'h9, 32'h9);
    rd(ADDR_RX_DATA, 32'h1FF, 32'h3C);
    rd(ADDR_STATUS, 32'h8, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL_ONE, 32'h5 | (i[1] << 3));
      i_tx.send(9'h007, 8, i[1] + 1, i[0], 1, 0);
      rd(ADDR_STATUS, 32'h10, i[0] << 4);
      rd(ADDR_RX_DATA, 32'h1FF, 32'h7);
    end
    apb(1'b1, ADDR_CTRL_ONE, 32'h1);
    apb(1'b1, ADDR_CTRL_TWO, 32'hB);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL_ONE, {30'h0, i[1], 1'b1});
      c = irqs;
      i_tx.send(ad[i], 8 + i[1], 0, 0, 1, 0);
      chk("address irq", irqs - c, i[0]);
      rd(ADDR_STATUS, 32'h1, 32'h1);
      rd(ADDR_RX_DATA, 32'h1FF, ad[i]);
    end
    apb(1'b1, ADDR_CTRL_ONE, 32'h1);
    apb(1'b1, ADDR_CTRL_TWO, 32'h19);
    c = irqs;
    tx_empty <= 1'b1;
    repeat (4) @(posedge pclk);
    tx_idle <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("tx irq", irqs - c, 1);
    apb(1'b1, ADDR_CTRL_TWO, 32'h29);
    {tx_empty, tx_idle} <= 2'b00;
    repeat (4) @(posedge pclk);
    c = irqs;
    {tx_empty, tx_idle} <= 2'b11;
    repeat (4) @(posedge pclk);
    chk("tx idle irq", irqs - c, 1);
    fork
      i_tx.send(9'h03A, 8, 0, 0, 1, 0);
      begin
        repeat (50) @(posedge pclk);
        clock_halted <= 1'b1;
        repeat (200) @(posedge pclk);
        clock_halted <= 1'b0;
      end
    join
    rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_RX_DATA, 32'h1FF, 32'h3A);
    wake(32'hD, 1'b1, 1, 1);
    wake(32'hD, 1'b0, 1, 0);
    wake(32'h9, 1'b1, 0, 0);
    summarize();
  end
endmodule : urx_core_test
`default_nettype wire
